// [verilog/out_sel_consts.svh]
// Constants for the output terminal function selection block
`ifndef OUT_SEL_CONSTS_SVH
`define OUT_SEL_CONSTS_SVH

// Register addresses (word addresses on the plain port)
`define ADDR_RUN_SEL 4'h0
`define ADDR_RELAY_SEL 4'h1
`define ADDR_SAFETY_SEL 4'h2
`define ADDR_REMOTE_OUT 4'h3
`define ADDR_EXT_DISPLAY 4'h4
`define ADDR_STATUS 4'h5
`define ADDR_IRQ_CLEAR 4'h6
`define ADDR_IRQ_ENABLE 4'h7
`define ADDR_TERM_STATE 4'h8

// Reset values
`define RST_RUN_SEL 16'h0000
`define RST_RELAY_SEL 16'h0063
`define RST_SAFETY_SEL 16'h0050
`define RST_REMOTE_OUT 12'h000
`define RST_EXT_DISPLAY 16'h0000

// Function codes
`define CODE_RUN 16'h0000
`define CODE_SAFE1 16'h0050
`define CODE_MONITOR_TWO 16'h0051
`define CODE_MONITOR_TWO_NEG 16'h00b5
`define CODE_FAULT 16'h0063
`define CODE_REMOTE_BLOCKED_RELAY 16'h005d
`define CODE_REMOTE_BLOCKED_RELAY_N 16'h00c1
`define CODE_NONE 16'h270f
`define NEG_OFFSET 16'h0064
`define EXT_DISPLAY_OPEN 16'h0000

// Field positions
`define REMOTE_SAFETY_BIT 0
`define STAT_REJECT_BIT 0
`define STAT_SAFE_FAULT_BIT 1
`define STAT_WIDTH 2

`endif

// [verilog/out_sel_pkg.sv]
// Types for the output terminal function selection block
package out_sel_pkg;

  typedef struct packed {
    logic run_term;
    logic relay_term;
    logic safety_term;
  } term_s;

  typedef enum logic [1:0] {
    sel_run,
    sel_relay,
    sel_safety
  } sel_kind_e;

  typedef logic [15:0] code_t;

endpackage : out_sel_pkg

// [verilog/output_terminal_function_select.sv]
// Output terminal function selection with safety monitor and remote bit
//
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/1ns
`include "out_sel_consts.svh"

module output_terminal_function_select
  import out_sel_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rstn_in,
  // Register port
  input wire logic [3:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rdata_out,
  // Drive status inputs (pins, synchronised here)
  input wire logic running_in,
  input wire logic fault_in,
  input wire logic safety_fault_in,
  input wire logic safety_monitor_one_in,
  input wire logic [63:0] status_vec_in,
  // Terminals
  output term_s terms_out,
  output logic irq_out
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [67:0] sync_a;
  logic [67:0] sync_b;

  // Pins are asynchronous to this clock, so two stages before any use
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= {safety_monitor_one_in, safety_fault_in, fault_in,
                 running_in, status_vec_in};
      sync_b <= sync_a;
    end
  end

  logic [63:0] stat_s;
  logic running_s;
  logic fault_s;
  logic safety_fault_s;
  logic safe1_s;
  logic monitor_two;

  assign stat_s = sync_b[63:0];
  assign running_s = sync_b[64];
  assign fault_s = sync_b[65];
  assign safety_fault_s = sync_b[66];
  assign safe1_s = sync_b[67];
  assign monitor_two = ~safety_fault_s;

  // ****************************************************************
  // Code legality
  // ****************************************************************
  // Positive-logic base codes; code_ok still refuses 005d for the relay selector
  function automatic logic base_ok(input code_t c);
    case (c)
      16'h0000,
      16'h0001,
      16'h0003,
      16'h0004,
      16'h0007,
      16'h0008,
      16'h000b,
      16'h000c,
      16'h000d,
      16'h000e,
      16'h000f,
      16'h0010,
      16'h0019,
      16'h001a,
      16'h002e,
      16'h002f,
      16'h0040,
      16'h0046,
      16'h0050,
      16'h0051,
      16'h005a,
      16'h005b,
      16'h005d,
      16'h005f,
      16'h0060,
      16'h0062,
      16'h0063: base_ok = 1'b1;
      default: base_ok = 1'b0;
    endcase
  endfunction : base_ok

  // Negative codes mirror positives at plus 100
  function automatic logic code_ok(input code_t c, input sel_kind_e k);
    logic ok;
    ok = 1'b0;
    if (c == `CODE_NONE) begin
      ok = (k != sel_safety);
    end else if (c < `NEG_OFFSET) begin
      ok = base_ok(c);
    end else if (c < (`NEG_OFFSET + `NEG_OFFSET)) begin
      ok = base_ok(c - `NEG_OFFSET);
    end
    if (k == sel_relay && (c == `CODE_REMOTE_BLOCKED_RELAY ||
        c == `CODE_REMOTE_BLOCKED_RELAY_N)) begin
      ok = 1'b0;
    end
    code_ok = ok;
  endfunction : code_ok

  // ****************************************************************
  // Registers
  // ****************************************************************
  code_t run_terminal_selector;
  code_t relay_terminal_selector;
  code_t safety_terminal_selector;
  logic [11:0] remote_output_word;
  code_t extended_display_setting;
  logic [`STAT_WIDTH-1:0] irq_status;
  logic [`STAT_WIDTH-1:0] irq_enable;

  logic sel_open;
  logic wr_run;
  logic wr_relay;
  logic wr_safety;
  logic run_ok;
  logic relay_ok;
  logic safety_ok;
  logic reject_evt;
  logic wr_remote;
  logic wr_display;
  logic wr_clear;
  logic wr_enable;

  // The display setting stays writable, else the lock could never lift
  assign sel_open = (extended_display_setting == `EXT_DISPLAY_OPEN);
  assign wr_run = wr_in && addr_in == `ADDR_RUN_SEL;
  assign wr_relay = wr_in && addr_in == `ADDR_RELAY_SEL;
  assign wr_safety = wr_in && addr_in == `ADDR_SAFETY_SEL;
  assign wr_remote = wr_in && addr_in == `ADDR_REMOTE_OUT;
  assign wr_display = wr_in && addr_in == `ADDR_EXT_DISPLAY;
  assign wr_clear = wr_in && addr_in == `ADDR_IRQ_CLEAR;
  assign wr_enable = wr_in && addr_in == `ADDR_IRQ_ENABLE;
  assign run_ok = sel_open && code_ok(wdata_in, sel_run);
  assign relay_ok = sel_open && code_ok(wdata_in, sel_relay);
  assign safety_ok = sel_open && code_ok(wdata_in, sel_safety);
  // A refused selector write is reported so software can tell it failed
  assign reject_evt = (wr_run && !run_ok) || (wr_relay && !relay_ok) ||
                      (wr_safety && !safety_ok);

  // ****************************************************************
  // Register storage
  // ****************************************************************

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      run_terminal_selector <= `RST_RUN_SEL;
    end else if (wr_run && run_ok) begin
      run_terminal_selector <= wdata_in;
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      relay_terminal_selector <= `RST_RELAY_SEL;
    end else if (wr_relay && relay_ok) begin
      relay_terminal_selector <= wdata_in;
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      safety_terminal_selector <= `RST_SAFETY_SEL;
    end else if (wr_safety && safety_ok) begin
      safety_terminal_selector <= wdata_in;
    end
  end

  // Only bit 0 has a use; the other bits are kept for read back
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      remote_output_word <= `RST_REMOTE_OUT;
    end else if (wr_remote) begin
      remote_output_word <= wdata_in[11:0];
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      extended_display_setting <= `RST_EXT_DISPLAY;
    end else if (wr_display) begin
      extended_display_setting <= wdata_in;
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  logic safe_fault_d;
  logic safe_fault_rise;
  logic [`STAT_WIDTH-1:0] irq_set;
  logic [`STAT_WIDTH-1:0] irq_clr;

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      safe_fault_d <= 1'b0;
    end else begin
      safe_fault_d <= safety_fault_s;
    end
  end

  // Only the edge counts, so a standing fault does not refire after a clear
  assign safe_fault_rise = safety_fault_s && !safe_fault_d;

  always_comb begin
    irq_set = '0;
    irq_set[`STAT_REJECT_BIT] = reject_evt;
    irq_set[`STAT_SAFE_FAULT_BIT] = safe_fault_rise;
  end

  assign irq_clr = wr_clear ? wdata_in[`STAT_WIDTH-1:0] : '0;

  // Set wins over a clear in the same cycle
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_enable <= '0;
    end else if (wr_enable) begin
      irq_enable <= wdata_in[`STAT_WIDTH-1:0];
    end
  end

  assign irq_out = |(irq_status & irq_enable);

  // ****************************************************************
  // Terminal mapping
  // ****************************************************************
  // Picks the signal a code names; unlisted codes below 0040 read the status vector, others give low before negation
  function automatic logic map_code(input code_t c);
    code_t b;
    logic v;
    logic neg;
    neg = (c >= `NEG_OFFSET) && (c != `CODE_NONE);
    b = neg ? code_t'(c - `NEG_OFFSET) : c;
    case (b)
      `CODE_RUN: v = running_s;
      `CODE_FAULT: v = fault_s;
      `CODE_SAFE1: v = safe1_s;
      `CODE_MONITOR_TWO: v = monitor_two;
      `CODE_NONE: v = 1'b0;
      // Drive functions that live outside this block read as off
      16'h0040,
      16'h0046,
      16'h005a,
      16'h005b,
      16'h005d,
      16'h005f,
      16'h0060,
      16'h0062: v = 1'b0;
      default: v = (b < 16'h0040) ? stat_s[b[5:0]] : 1'b0;
    endcase
    map_code = neg ? ~v : v;
  endfunction : map_code

  term_s next_terms;
  code_t sel_code [3];
  logic mapped [3];

  // Selector codes in the bit order of the packed terminal struct
  assign sel_code[2] = run_terminal_selector;
  assign sel_code[1] = relay_terminal_selector;
  assign sel_code[0] = safety_terminal_selector;

  // One mapper per terminal; each reads live status, hence always_comb
  for (genvar t = 0; t < 3; t++) begin : g_term
    always_comb begin
      mapped[t] = map_code(sel_code[t]);
    end
  end

  always_comb begin
    next_terms.run_term = mapped[2];
    next_terms.relay_term = mapped[1];
    // Remote bit is ORed with the selected safety function, forcing the terminal high when set
    next_terms.safety_term = mapped[0] |
                             remote_output_word[`REMOTE_SAFETY_BIT];
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      terms_out <= '0;
    end else begin
      terms_out <= next_terms;
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_out <= '0;
    end else if (rd_in) begin
      case (addr_in)
        `ADDR_RUN_SEL: rdata_out <= run_terminal_selector;
        `ADDR_RELAY_SEL: rdata_out <= relay_terminal_selector;
        `ADDR_SAFETY_SEL: rdata_out <= safety_terminal_selector;
        `ADDR_REMOTE_OUT: rdata_out <= {4'h0, remote_output_word};
        `ADDR_EXT_DISPLAY: rdata_out <= extended_display_setting;
        `ADDR_STATUS: rdata_out <= {14'h0000, irq_status};
        `ADDR_IRQ_ENABLE: rdata_out <= {14'h0000, irq_enable};
        `ADDR_TERM_STATE: rdata_out <= {13'h0000, terms_out};
        default: rdata_out <= 16'h0000;
      endcase
    end else begin
      rdata_out <= 16'h0000;
    end
  end

endmodule : output_terminal_function_select

// [test/term_loads.sv]
// Model of the external loads on the three terminals
`timescale 1ns/1ns
module term_loads
  import out_sel_pkg::*;
(
  // Terminals
  input wire term_s terms_in,
  // Load states
  output logic [2:0] lamp_out
);
  // Resistive loads: no delay of their own
  assign lamp_out = terms_in;
endmodule : term_loads

// [test/out_sel_props.sv]
// Assertion checker for the output terminal selector
`timescale 1ns/1ns
module out_sel_props
  import out_sel_pkg::*;
(
  // Clock, reset, register port
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic [3:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [15:0] rdata_out,
  // Outputs
  input wire term_s terms_out,
  input wire logic irq_out
);
  // ****
  // Properties
  // ****
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  AST_RD_IDLE: assert property (!$past(rd_in) |-> rdata_out == 16'h0000)
    else $error("read data outside read slot");
  AST_CLR_READ: assert property (rd_in && addr_in == 4'h6 |=> !rdata_out)
    else $error("clear register read not zero");
  AST_UNMAPPED: assert property (rd_in && addr_in > 4'h8 |=> !rdata_out)
    else $error("unmapped read not zero");
  AST_RELAY_REFUSE: assert property (
    wr_in && addr_in == 4'h1 && wdata_in == 16'h005d ##1 rd_in &&
    addr_in == 4'h1 |=> rdata_out != 16'h005d)
    else $error("relay selector took a refused code");
  AST_SAFETY_REFUSE: assert property (
    wr_in && addr_in == 4'h2 && wdata_in == 16'h270f ##1 rd_in &&
    addr_in == 4'h2 |=> rdata_out != 16'h270f)
    else $error("safety selector took a refused code");
  AST_UNLISTED: assert property (
    wr_in && addr_in < 4'h3 && wdata_in == 16'h0002 ##1 rd_in &&
    addr_in == $past(addr_in) |=> rdata_out != 16'h0002)
    else $error("selector took an unlisted code");
  AST_REMOTE_ON: assert property (
    wr_in && addr_in == 4'h3 && wdata_in[0] ##1 !wr_in [*2]
    |=> terms_out.safety_term)
    else $error("remote bit did not drive safety terminal");
  AST_IRQ_OFF: assert property (
    wr_in && addr_in == 4'h7 && wdata_in[1:0] == 2'b00 |=> !irq_out)
    else $error("interrupt high with nothing enabled");
endmodule : out_sel_props

bind output_terminal_function_select out_sel_props props_u (
  .core_clk_in(core_clk_in), .rstn_in(rstn_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .terms_out(terms_out), .irq_out(irq_out));

// [test/testbench.sv]
// Self-checking testbench for the output terminal selector
`timescale 1ns/1ns
module testbench;
  logic core_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [3:0] addr_in = 4'h0;
  logic [15:0] wdata_in = 16'h0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic safety_fault_in = 1'b0;
  logic running_in = 1'b0;
  logic fault_in = 1'b0;
  logic safety_monitor_one_in = 1'b0;
  logic [15:0] rdata_out;
  logic irq_out;
  logic [2:0] lamp;
  out_sel_pkg::term_s terms_out;
  int n_mismatch = 0;
  int cmp_count = 0;

  always #20 core_clk_in = ~core_clk_in;

  // The status vector is held quiet; the single pins are driven
  output_terminal_function_select dut_u (
    .core_clk_in(core_clk_in), .rstn_in(rstn_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .running_in(running_in), .fault_in(fault_in),
    .safety_fault_in(safety_fault_in),
    .safety_monitor_one_in(safety_monitor_one_in),
    .status_vec_in(64'h0000_0000_0000_0000), .terms_out(terms_out),
    .irq_out(irq_out));
  term_loads loads_u (.terms_in(terms_out), .lamp_out(lamp));

  // ****
  // Tasks
  // ****
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk_in);
    rd_in <= 1'b0;
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
  endtask : wr
  task idle(input int n);
    repeat (n) @(posedge core_clk_in) wr_in <= 1'b0;
  endtask : idle
  task chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task rdc(input logic [3:0] a, input logic [15:0] exp);
    @(posedge core_clk_in);
    wr_in <= 1'b0;
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge core_clk_in);
    rd_in <= 1'b0;
    #1 chk(rdata_out, exp);
  endtask : rdc
  // Terminals lag the inputs by three cycles, so wait five
  task tchk(input int s, input logic e);
    idle(5);
    #1 chk({15'h0000, lamp[2 - s]}, {15'h0000, e});
  endtask : tchk
  task results;
    $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results

  initial begin
    #2000000 n_mismatch++;
    results;
  end

  // ****
  // Tests
  // ****
  initial begin
    repeat (2) @(posedge core_clk_in);
    rstn_in <= 1'b1;
    rdc(4'h0, 16'h0000);
    rdc(4'h1, 16'h0063);
    rdc(4'h2, 16'h0050);
    @(posedge core_clk_in);
    running_in <= 1'b1;
    fault_in <= 1'b1;
    safety_monitor_one_in <= 1'b1;
    tchk(0, 1'b1);
    tchk(1, 1'b1);
    tchk(2, 1'b1);
    rdc(4'h8, 16'h0007);
    @(posedge core_clk_in);
    running_in <= 1'b0;
    fault_in <= 1'b0;
    safety_monitor_one_in <= 1'b0;
    tchk(0, 1'b0);
    tchk(1, 1'b0);
    tchk(2, 1'b0);
    $display("test reset_values done");
    for (int s = 0; s < 3; s++) begin
      @(posedge core_clk_in) safety_fault_in <= 1'b0;
      wr(4'(s), 16'h0051);
      tchk(s, 1'b1);
      wr(4'(s), 16'h00b5);
      tchk(s, 1'b0);
      @(posedge core_clk_in) safety_fault_in <= 1'b1;
      tchk(s, 1'b1);
      rdc(4'(s), 16'h00b5);
      wr(4'(s), 16'h0051);
      tchk(s, 1'b0);
    end
    $display("test safety_monitor done");
    wr(4'h1, 16'h005d);
    rdc(4'h1, 16'h0051);
    wr(4'h0, 16'h005d);
    rdc(4'h0, 16'h005d);
    wr(4'h2, 16'h270f);
    rdc(4'h2, 16'h0051);
    wr(4'h0, 16'h270f);
    rdc(4'h0, 16'h270f);
    wr(4'h1, 16'h0002);
    rdc(4'h1, 16'h0051);
    wr(4'h1, 16'h0066);
    tchk(1, 1'b0);
    rdc(4'h1, 16'h0051);
    wr(4'h4, 16'h0001);
    wr(4'h0, 16'h0000);
    rdc(4'h0, 16'h270f);
    wr(4'h4, 16'h0000);
    wr(4'h0, 16'h0000);
    rdc(4'h0, 16'h0000);
    rdc(4'h4, 16'h0000);
    $display("test refusals done");
    rdc(4'h5, 16'h0003);
    wr(4'h7, 16'h0001);
    idle(1);
    #1 chk({15'h0000, irq_out}, 16'h0001);
    wr(4'h6, 16'h0003);
    idle(1);
    #1 chk({15'h0000, irq_out}, 16'h0000);
    rdc(4'h5, 16'h0000);
    wr(4'h7, 16'h0000);
    rdc(4'h6, 16'h0000);
    rdc(4'h9, 16'h0000);
    $display("test interrupts done");
    wr(4'h3, 16'h0001);
    tchk(2, 1'b1);
    rdc(4'h3, 16'h0001);
    rdc(4'h8, 16'h0001);
    wr(4'h3, 16'h0000);
    tchk(2, 1'b0);
    $display("test remote_bit done");
    results;
  end
endmodule : testbench
